// ### core/peripheral_access_wait_gen.sv
// AHB-Lite bridge that stalls the CPU on slow peripheral register accesses
//
// The implementer's own choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/1ps
`include "wait_gen_params.svh"

// Behaviour
// - While a wait runs the bus stays stalled until correct data is moved.
// - A write to the watchdog mode register stalls exactly three cycles.
// - A read of either UART receive status register stalls one cycle.
// - Converter group writes stall 2 to 9 cycles, or 2 to 5 when fast.
// - Converter result reads stall 1 to 9 cycles, or 1 to 5 when fast.
// - Converter waits are two macro periods over a CPU period, plus one.
// - A leftover fraction is dropped unless it passes the clock low time.
// - The macro clock is the input clock over two if bit 5 is set, else four.
// - A computed count of one inserts no wait.
// - A result read still stalls one cycle where group writes stall none.
// - All waits are counted in CPU clock cycles.
module peripheral_access_wait_gen (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Peripheral read data, from logic on hclk
  input wire logic [7:0] uart_a_status,
  input wire logic [7:0] uart_b_status,
  input wire logic [7:0] adc_result,
  // Oscillator stop level, from another domain
  input wire logic main_osc_stop_ctrl,
  // Peripheral settings
  output logic [7:0] watchdog_mode,
  output logic [7:0] adc_mode,
  output logic [7:0] adc_channel,
  output logic [7:0] pf_mode,
  output logic [7:0] pf_threshold,
  // Access pulses toward the peripherals
  output logic watchdog_wr_pulse,
  output logic uart_a_rd_pulse,
  output logic uart_b_rd_pulse,
  output logic adc_rd_pulse
);

  logic [7:0] watchdog_mode_reg_r;
  logic [7:0] adc_mode_reg_r;
  logic [7:0] adc_channel_select_reg_r;
  logic [7:0] power_fail_compare_mode_reg_r;
  logic [7:0] power_fail_threshold_reg_r;
  logic [2:0] cpu_div_r;
  logic fault_r;
  logic [3:0] last_waits_r;
  wait_gen_pkg::bus_req_t dreq_r;
  wait_gen_pkg::bus_req_t areq;
  wait_gen_pkg::phase_state_t state_r;
  logic dphase_r;
  logic hreadyout_r;
  logic [31:0] hrdata_r;
  logic [2:0] osc_sync_r;
  logic osc_stopped_r;
  logic accept;
  logic commit;
  logic conversion_speed_select;
  logic [3:0] calc_waits;
  logic [3:0] req_waits;
  logic cnt_busy;
  logic cnt_last;
  logic wr_pulse_r;
  logic ua_pulse_r;
  logic ub_pulse_r;
  logic adc_pulse_r;

  // Converter group wait count from CPU divider and speed select
  function automatic logic [3:0] adc_waits(input logic [2:0] div,
                                           input logic fast);
    logic [1:0] macro_log;
    logic [7:0] quarters;
    logic [7:0] whole;
    macro_log = fast ? `MACRO_LOG_FAST : `MACRO_LOG_SLOW;
    // Two macro periods in quarter CPU cycles, plus one cycle
    quarters = ((`MACRO_PERIODS * `QUARTERS) << macro_log) >> div;
    quarters = quarters + `QUARTERS;
    whole = quarters >> 2;
    // Fraction equal to the low time is dropped, above it rounds up
    if (quarters[1:0] > `LOW_QUARTERS) begin
      whole = whole + 8'h01;
    end
    adc_waits = whole[3:0];
  endfunction

  // Register read mux, narrow data in the low bits
  function automatic logic [31:0] read_value(input logic [7:0] a);
    logic [7:0] v;
    v = `RST_BYTE;
    if (a == `OFS_WDT_MODE) begin
      v = watchdog_mode_reg_r;
    end else if (a == `OFS_UART_A_STAT) begin
      v = uart_a_status;
    end else if (a == `OFS_UART_B_STAT) begin
      v = uart_b_status;
    end else if (a == `OFS_ADC_MODE) begin
      v = adc_mode_reg_r;
    end else if (a == `OFS_ADC_CHAN) begin
      v = adc_channel_select_reg_r;
    end else if (a == `OFS_PF_MODE) begin
      v = power_fail_compare_mode_reg_r;
    end else if (a == `OFS_PF_THRESH) begin
      v = power_fail_threshold_reg_r;
    end else if (a == `OFS_ADC_RESULT) begin
      v = adc_result;
    end else if (a == `OFS_CPU_DIV) begin
      v = {5'h00, cpu_div_r};
    end else if (a == `OFS_WAIT_STAT) begin
      v[`STAT_FAULT_BIT] = fault_r;
      v[`STAT_BUSY_BIT] = cnt_busy;
      v[`STAT_LAST_MSB:`STAT_LAST_LSB] = last_waits_r;
    end
    read_value = {24'h000000, v};
  endfunction

  // Converter group write target
  function automatic logic is_adc_group(input logic [7:0] a);
    is_adc_group = (a == `OFS_ADC_MODE) || (a == `OFS_ADC_CHAN) ||
                   (a == `OFS_PF_MODE) || (a == `OFS_PF_THRESH);
  endfunction

  assign areq.addr = haddr[7:0];
  assign areq.write = hwrite;
  assign accept = hsel && htrans[1] && hready;
  assign commit = dphase_r && hreadyout_r;
  assign conversion_speed_select = adc_mode_reg_r[`ADC_SPEED_BIT];
  assign calc_waits = adc_waits(cpu_div_r, conversion_speed_select);

  // Wait count of the transfer now in its address phase
  always_comb begin
    req_waits = `WAITS_NONE;
    if (haddr[31:8] != 24'h000000) begin
      req_waits = `WAITS_NONE;
    end else if (hwrite && areq.addr == `OFS_WDT_MODE) begin
      req_waits = `WAITS_WDT;
    end else if (!hwrite && (areq.addr == `OFS_UART_A_STAT ||
                             areq.addr == `OFS_UART_B_STAT)) begin
      req_waits = `WAITS_UART;
    end else if (hwrite && is_adc_group(areq.addr)) begin
      // A count of one means the access needs no stall
      req_waits = (calc_waits == `WAITS_ONE) ? `WAITS_NONE : calc_waits;
    end else if (!hwrite && areq.addr == `OFS_ADC_RESULT) begin
      // The result read keeps one cycle even where writes have none
      req_waits = calc_waits;
    end
  end

  wait_counter u_wait_counter (
    .hclk(hclk),
    .hresetn(hresetn),
    .load(accept),
    .load_value(req_waits),
    .busy(cnt_busy),
    .last(cnt_last)
  );

  // Oscillator stop level, three stages, change taken when two agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      osc_sync_r <= 3'h0;
      osc_stopped_r <= 1'b0;
    end else begin
      osc_sync_r <= {osc_sync_r[1:0], main_osc_stop_ctrl};
      if (osc_sync_r[1] == osc_sync_r[2]) begin
        osc_stopped_r <= osc_sync_r[2];
      end
    end
  end

  // Data phase tracking and one-hot wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= wait_gen_pkg::ST_IDLE;
      dphase_r <= 1'b0;
      dreq_r <= '0;
    end else begin
      if (accept) begin
        dreq_r <= areq;
        dphase_r <= (haddr[31:8] == 24'h000000);
      end else if (commit) begin
        dphase_r <= 1'b0;
      end
      case (state_r)
        wait_gen_pkg::ST_IDLE: begin
          if (accept && req_waits != `WAITS_NONE) begin
            state_r <= wait_gen_pkg::ST_WAIT;
          end
        end
        wait_gen_pkg::ST_WAIT: begin
          if (cnt_last) begin
            state_r <= wait_gen_pkg::ST_IDLE;
          end
        end
        default: begin
          state_r <= wait_gen_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Ready drops for exactly the wait count; the CPU cannot move on
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_r <= 1'b1;
    end else if (accept && req_waits != `WAITS_NONE) begin
      hreadyout_r <= 1'b0;
    end else if (cnt_last) begin
      hreadyout_r <= 1'b1;
    end
  end

  // Read data; a stalled read samples again on its last wait cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h00000000;
    end else if (accept && !hwrite) begin
      hrdata_r <= (haddr[31:8] == 24'h000000) ? read_value(areq.addr)
                                               : 32'h00000000;
    end else if (cnt_last && !dreq_r.write) begin
      hrdata_r <= read_value(dreq_r.addr);
    end
  end

  // Register writes land at the end of the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      watchdog_mode_reg_r <= `RST_BYTE;
      adc_mode_reg_r <= `RST_BYTE;
      adc_channel_select_reg_r <= `RST_BYTE;
      power_fail_compare_mode_reg_r <= `RST_BYTE;
      power_fail_threshold_reg_r <= `RST_BYTE;
      cpu_div_r <= `RST_DIV;
    end else if (commit && dreq_r.write) begin
      if (dreq_r.addr == `OFS_WDT_MODE) begin
        watchdog_mode_reg_r <= hwdata[7:0];
      end else if (dreq_r.addr == `OFS_ADC_MODE) begin
        adc_mode_reg_r <= hwdata[7:0];
      end else if (dreq_r.addr == `OFS_ADC_CHAN) begin
        adc_channel_select_reg_r <= hwdata[7:0];
      end else if (dreq_r.addr == `OFS_PF_MODE) begin
        power_fail_compare_mode_reg_r <= hwdata[7:0];
      end else if (dreq_r.addr == `OFS_PF_THRESH) begin
        power_fail_threshold_reg_r <= hwdata[7:0];
      end else if (dreq_r.addr == `OFS_CPU_DIV) begin
        // Divider settings past the slowest one clamp to it
        cpu_div_r <= (hwdata[2:0] > `DIV_MAX) ? `DIV_MAX : hwdata[2:0];
      end
    end
  end

  // Misuse flag: a waited access while the main oscillator is stopped.
  // Set beats a clear in the same cycle so no event is lost.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fault_r <= 1'b0;
    end else if (accept && req_waits != `WAITS_NONE && osc_stopped_r) begin
      fault_r <= 1'b1;
    end else if (commit && dreq_r.write && dreq_r.addr == `OFS_WAIT_STAT &&
                 hwdata[`STAT_FAULT_BIT]) begin
      fault_r <= 1'b0;
    end
  end

  // Wait count of the latest transfer, for software to inspect
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last_waits_r <= `WAITS_NONE;
    end else if (accept) begin
      last_waits_r <= req_waits;
    end
  end

  // One-cycle access pulses, issued as the transfer completes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pulse_r <= 1'b0;
      ua_pulse_r <= 1'b0;
      ub_pulse_r <= 1'b0;
      adc_pulse_r <= 1'b0;
    end else begin
      wr_pulse_r <= commit && dreq_r.write &&
                    dreq_r.addr == `OFS_WDT_MODE;
      ua_pulse_r <= commit && !dreq_r.write &&
                    dreq_r.addr == `OFS_UART_A_STAT;
      ub_pulse_r <= commit && !dreq_r.write &&
                    dreq_r.addr == `OFS_UART_B_STAT;
      adc_pulse_r <= commit && !dreq_r.write &&
                     dreq_r.addr == `OFS_ADC_RESULT;
    end
  end

  // Every output but hresp straight from a flip-flop; hresp is tied to OKAY
  assign hrdata = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp = 1'b0;
  assign watchdog_mode = watchdog_mode_reg_r;
  assign adc_mode = adc_mode_reg_r;
  assign adc_channel = adc_channel_select_reg_r;
  assign pf_mode = power_fail_compare_mode_reg_r;
  assign pf_threshold = power_fail_threshold_reg_r;
  assign watchdog_wr_pulse = wr_pulse_r;
  assign uart_a_rd_pulse = ua_pulse_r;
  assign uart_b_rd_pulse = ub_pulse_r;
  assign adc_rd_pulse = adc_pulse_r;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  property p_rd_fresh;
    $rose(hreadyout_r) && dphase_r && !dreq_r.write |->
      hrdata_r == read_value(dreq_r.addr);
  endproperty
  a_rd_fresh: assert property (p_rd_fresh)
    else $error("stalled read ended with stale data");

  property p_wdt;
    accept && hwrite && haddr == 32'h00000000 |=>
      !hreadyout_r [*3] ##1 hreadyout_r;
  endproperty
  a_wdt: assert property (p_wdt)
    else $error("watchdog write did not stall three cycles");

  property p_uart;
    accept && !hwrite && (haddr == {24'h000000, `OFS_UART_A_STAT} ||
                          haddr == {24'h000000, `OFS_UART_B_STAT}) |=>
      !hreadyout_r ##1 hreadyout_r;
  endproperty
  a_uart: assert property (p_uart)
    else $error("uart status read did not stall one cycle");

  property p_grp_wr;
    accept && hwrite && haddr[31:8] == 24'h000000 &&
      is_adc_group(haddr[7:0]) |->
      req_waits == `WAITS_NONE || (req_waits >= 4'h2 &&
      req_waits <= (conversion_speed_select ? 4'h5 : 4'h9));
  endproperty
  a_grp_wr: assert property (p_grp_wr)
    else $error("converter group write wait out of range");

  property p_res_rd;
    accept && !hwrite && haddr == {24'h000000, `OFS_ADC_RESULT} |->
      req_waits >= 4'h1 &&
      req_waits <= (conversion_speed_select ? 4'h5 : 4'h9);
  endproperty
  a_res_rd: assert property (p_res_rd)
    else $error("result read wait out of range");

  property p_fastest;
    cpu_div_r == 3'h0 |->
      calc_waits == (conversion_speed_select ? 4'h5 : 4'h9);
  endproperty
  a_fastest: assert property (p_fastest)
    else $error("undivided cpu clock gives wrong converter wait");

  property p_round;
    cpu_div_r == 3'h3 |->
      calc_waits == (conversion_speed_select ? 4'h1 : 4'h2);
  endproperty
  a_round: assert property (p_round)
    else $error("fraction rounding or macro divisor wrong");

  property p_one_none;
    accept && hwrite && haddr[31:8] == 24'h000000 &&
      is_adc_group(haddr[7:0]) && calc_waits == 4'h1 |=> hreadyout_r;
  endproperty
  a_one_none: assert property (p_one_none)
    else $error("count of one still stalled a write");

  property p_one_read;
    accept && !hwrite && haddr == {24'h000000, `OFS_ADC_RESULT} &&
      calc_waits == 4'h1 |=> !hreadyout_r ##1 hreadyout_r;
  endproperty
  a_one_read: assert property (p_one_read)
    else $error("result read lost its single wait");

  property p_other;
    accept && req_waits == `WAITS_NONE |=> hreadyout_r;
  endproperty
  a_other: assert property (p_other)
    else $error("plain access was stalled");

endmodule

// ### core/wait_gen_params.svh
// Offsets, field positions, reset values and timing figures of the wait generator
`ifndef WAIT_GEN_PARAMS_SVH
`define WAIT_GEN_PARAMS_SVH

// Register byte offsets
`define OFS_WDT_MODE 8'h00
`define OFS_UART_A_STAT 8'h04
`define OFS_UART_B_STAT 8'h08
`define OFS_ADC_MODE 8'h0c
`define OFS_ADC_CHAN 8'h10
`define OFS_PF_MODE 8'h14
`define OFS_PF_THRESH 8'h18
`define OFS_ADC_RESULT 8'h1c
`define OFS_CPU_DIV 8'h20
`define OFS_WAIT_STAT 8'h24

// Field positions
`define ADC_SPEED_BIT 5
`define STAT_FAULT_BIT 0
`define STAT_BUSY_BIT 1
`define STAT_LAST_LSB 4
`define STAT_LAST_MSB 7

// Reset values and the divider clamp limit
`define RST_BYTE 8'h00
`define RST_DIV 3'h0
`define DIV_MAX 3'h4

// Fixed wait counts in CPU clocks
`define WAITS_WDT 4'h3
`define WAITS_UART 4'h1
`define WAITS_NONE 4'h0
`define WAITS_ONE 4'h1

// Macro clock divisor as a power of two of the main input clock
`define MACRO_LOG_FAST 2'h1
`define MACRO_LOG_SLOW 2'h2

// Wait formula, worked in quarter CPU cycles
`define MACRO_PERIODS 8'h02
`define QUARTERS 8'h04
`define CPU_PERIOD_NS 10
`define CPU_LOW_NS 5
`define LOW_QUARTERS (2'((4 * `CPU_LOW_NS) / `CPU_PERIOD_NS))

`endif

// ### core/wait_gen_pkg.sv
// Types shared by the wait generator files
package wait_gen_pkg;

  // Captured address phase of one bus transfer
  typedef struct packed {
    logic [7:0] addr;
    logic write;
  } bus_req_t;

  // Data phase state, one-hot
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WAIT = 2'b10
  } phase_state_t;

endpackage

// ### core/wait_counter.sv
// Down counter of CPU clock wait cycles
`timescale 1ns/1ps
`include "wait_gen_params.svh"

module wait_counter (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control
  input wire logic load,
  input wire logic [3:0] load_value,
  // Status
  output logic busy,
  output logic last
);

  logic [3:0] count_r;

  // Counts hclk edges only, so every wait is a CPU clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_r <= `WAITS_NONE;
    end else if (load) begin
      count_r <= load_value;
    end else if (count_r != `WAITS_NONE) begin
      count_r <= count_r - `WAITS_ONE;
    end
  end

  assign busy = (count_r != `WAITS_NONE);
  assign last = (count_r == `WAITS_ONE);

endmodule

// ### testbench/cpu_bus_model.sv
// CPU side bus master model issuing single word transfers
`timescale 1ns/1ps

module cpu_bus_model (
  // Clock
  input wire logic hclk,
  // Bus toward the bridge
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata,
  // Answer from the bridge
  input wire logic hready,
  input wire logic [31:0] hrdata
);
  // Bus idle at time zero
  initial begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
  end

  // One word transfer; waits counts data phase edges with hready low.
  // Waited accesses need a running oscillator; one test breaks it on purpose
  task automatic xfer(input logic [7:0] addr, input logic wr,
      input logic [31:0] wdata, output logic [31:0] rdata,
      output logic [31:0] waits);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, addr};
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wdata;
    waits = 32'h0;
    @(posedge hclk);
    while (hready !== 1'b1) begin
      waits = waits + 32'h1;
      @(posedge hclk);
    end
    rdata = hrdata;
    // Stale data would hide a late sample in the bridge
    hwdata <= ~wdata;
  endtask
endmodule

// ### testbench/tb_peripheral_access_wait_gen.sv
// Self-checking bench for the peripheral access wait generator
`timescale 1ns/1ps
`include "wait_gen_params.svh"

module tb_peripheral_access_wait_gen;
  logic hclk;
  logic hresetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [7:0] uart_a_status;
  logic [7:0] uart_b_status;
  logic [7:0] adc_result;
  logic main_osc_stop_ctrl;
  logic [7:0] watchdog_mode;
  logic [7:0] adc_mode;
  logic [7:0] adc_channel;
  logic [7:0] pf_mode;
  logic [7:0] pf_threshold;
  logic watchdog_wr_pulse;
  logic uart_a_rd_pulse;
  logic uart_b_rd_pulse;
  logic adc_rd_pulse;
  logic [31:0] rd;
  logic [31:0] nw;
  int err_count = 0;
  int num_checks = 0;

  peripheral_access_wait_gen DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .uart_a_status(uart_a_status),
    .uart_b_status(uart_b_status), .adc_result(adc_result),
    .main_osc_stop_ctrl(main_osc_stop_ctrl),
    .watchdog_mode(watchdog_mode), .adc_mode(adc_mode),
    .adc_channel(adc_channel), .pf_mode(pf_mode),
    .pf_threshold(pf_threshold), .watchdog_wr_pulse(watchdog_wr_pulse),
    .uart_a_rd_pulse(uart_a_rd_pulse), .uart_b_rd_pulse(uart_b_rd_pulse),
    .adc_rd_pulse(adc_rd_pulse)
  );

  cpu_bus_model u_cpu (
    .hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata)
  );

  // 100 MHz clock
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // One transfer; result in rd, wait count in nw
  task automatic acc(input logic [7:0] a, input logic w,
      input logic [31:0] d);
    u_cpu.xfer(a, w, d, rd, nw);
  endtask

  // Converter wait count for CPU divider n, from the macro clock ratio
  function automatic logic [31:0] calc_w(input int n, input logic fast);
    int e;
    e = (fast ? 1 : 2) + 1 - n;
    // A half cycle equals the low width, so it is dropped
    calc_w = (e >= 0) ? (32'h1 << e) + 32'h1 : 32'h1;
  endfunction

  task automatic t_wdt;
    acc(`OFS_WDT_MODE, 1'b1, 32'h0000_005a);
    chk(nw, 32'h3);
    #1;
    chk({31'h0, watchdog_wr_pulse}, 32'h1);
    chk({24'h0, watchdog_mode}, 32'h5a);
    acc(`OFS_WDT_MODE, 1'b0, 32'h0);
    chk(nw, 32'h0);
    chk(rd, 32'h5a);
    $display("test watchdog done");
  endtask

  task automatic t_uart;
    uart_a_status <= 8'h3c;
    uart_b_status <= 8'hc3;
    acc(`OFS_UART_A_STAT, 1'b0, 32'h0);
    chk(nw, 32'h1);
    chk(rd, 32'h3c);
    #1;
    chk({31'h0, uart_a_rd_pulse}, 32'h1);
    acc(`OFS_UART_B_STAT, 1'b0, 32'h0);
    chk(nw, 32'h1);
    chk(rd, 32'hc3);
    #1;
    chk({31'h0, uart_b_rd_pulse}, 32'h1);
    acc(`OFS_UART_A_STAT, 1'b1, 32'h77);
    chk(nw, 32'h0);
    $display("test uart done");
  endtask

  task automatic t_adc;
    logic [31:0] w;
    logic [31:0] d;
    for (int f = 0; f < 2; f++) begin
      for (int n = 0; n < 5; n++) begin
        w = calc_w(n, f[0]);
        d = {26'h0, f[0], 2'h0, 3'(n)};
        acc(`OFS_CPU_DIV, 1'b1, 32'(n));
        chk(nw, 32'h0);
        // First write only sets the speed bit the rest depend on
        acc(`OFS_ADC_MODE, 1'b1, d);
        for (int k = 0; k < 4; k++) begin
          acc(8'(`OFS_ADC_MODE + 4 * k), 1'b1, d);
          chk(nw, (w == 32'h1) ? 32'h0 : w);
        end
        adc_result <= 8'(n * 17 + f);
        acc(`OFS_ADC_RESULT, 1'b0, 32'h0);
        chk(nw, w);
        chk(rd, 32'(n * 17 + f));
        // Settings are looked at once the last write has surely landed
        #1;
        chk({31'h0, adc_rd_pulse}, 32'h1);
        chk({24'h0, adc_mode}, d);
        chk({24'h0, adc_channel}, d);
        chk({24'h0, pf_mode}, d);
        chk({24'h0, pf_threshold}, d);
      end
    end
    $display("test converter done");
  endtask

  task automatic t_other;
    acc(8'h40, 1'b0, 32'h0);
    chk(nw, 32'h0);
    chk(rd, 32'h0);
    acc(`OFS_PF_MODE, 1'b0, 32'h0);
    chk(nw, 32'h0);
    chk(rd, 32'h24);
    acc(`OFS_ADC_RESULT, 1'b1, 32'h11);
    chk(nw, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    $display("test other done");
  endtask

  // Divider clamp, status word and the misuse flag of a stopped oscillator
  task automatic t_status;
    acc(`OFS_CPU_DIV, 1'b1, 32'h7);
    acc(`OFS_CPU_DIV, 1'b0, 32'h0);
    chk(rd, 32'h4);
    acc(`OFS_UART_A_STAT, 1'b0, 32'h0);
    acc(`OFS_WAIT_STAT, 1'b0, 32'h0);
    chk(rd, 32'h10);
    // Deliberate misuse: the flag must catch a waited access
    main_osc_stop_ctrl <= 1'b1;
    repeat (6) @(posedge hclk);
    acc(`OFS_UART_A_STAT, 1'b0, 32'h0);
    chk(nw, 32'h1);
    main_osc_stop_ctrl <= 1'b0;
    acc(`OFS_WAIT_STAT, 1'b0, 32'h0);
    chk(rd, 32'h11);
    acc(`OFS_WAIT_STAT, 1'b1, 32'h1);
    acc(`OFS_WAIT_STAT, 1'b0, 32'h0);
    chk(rd, 32'h0);
    $display("test status done");
  endtask

  // Mid-run reset returns ready, data and settings to their idle values
  task automatic t_reset;
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    chk({31'h0, hreadyout}, 32'h1);
    chk(hrdata, 32'h0);
    chk({24'h0, watchdog_mode}, 32'h0);
    chk({24'h0, adc_mode}, 32'h0);
    hresetn <= 1'b1;
    acc(`OFS_UART_B_STAT, 1'b0, 32'h0);
    chk(nw, 32'h1);
    $display("test reset done");
  endtask

  // Main sequence
  initial begin
    hresetn = 1'b0;
    uart_a_status = 8'h00;
    uart_b_status = 8'h00;
    adc_result = 8'h00;
    main_osc_stop_ctrl = 1'b0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    t_wdt();
    t_uart();
    t_adc();
    t_other();
    t_status();
    t_reset();
    wrap_up();
  end

  // Watchdog: the whole run needs about five hundred cycles
  initial begin
    repeat (20000) @(posedge hclk);
    err_count++;
    wrap_up();
  end
endmodule
